// file: verilog/fsr_consts.svh
// Constants for the fifth and sixth status registers of the serial flash.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

// Fifth register fields
`define FSR_R5_LOCK         7
`define FSR_R5_DUMMY_HI     6
`define FSR_R5_DUMMY_LO     4
`define FSR_R5_ERASE_SUSP   3
`define FSR_R5_PROG_SUSP    2
`define FSR_R5_ABORT_EN     1
`define FSR_R5_ALIGN        0
`define FSR_DUMMY_RST       3'h0
// Sixth register fields
`define FSR_R6_RES_HI       7
`define FSR_R6_RES_LO       6
`define FSR_R6_THR_HI       5
`define FSR_R6_THR_LO       3
`define FSR_R6_LOAD_HI      2
`define FSR_R6_LOAD_LO      1
`define FSR_R6_TIME         0
`define FSR_THR_RST         3'h0
`define FSR_LOAD_RST        2'h0
// Lock command and its two key bytes
`define FSR_OP_LOCK         8'h6f
`define FSR_LOCK_KEY1       8'h4d
`define FSR_LOCK_KEY2       8'h67
// Dummy-count codes and clock counts
`define FSR_DCODE_2         3'h0
`define FSR_DCODE_4         3'h1
`define FSR_DCODE_6         3'h2
`define FSR_DCODE_8         3'h3
`define FSR_DCODE_10        3'h4
`define FSR_DCLK_2          4'h2
`define FSR_DCLK_4          4'h4
`define FSR_DCLK_6          4'h6
`define FSR_DCLK_8          4'h8
`define FSR_DCLK_10         4'ha
`define FSR_MODE_CLKS       4'h2
// Supply test result encodings
`define FSR_RES_IDLE        2'h0
`define FSR_RES_BUSY        2'h1
`define FSR_RES_ABOVE       2'h2
`define FSR_RES_BELOW       2'h3
// Threshold in millivolts: base plus step per code
`define FSR_THR_BASE_MV     12'h708
`define FSR_THR_STEP_MV     12'h0c8
// Load durations
`define FSR_CLK_HZ          10000000
`define FSR_LOAD_SHORT_US   100
`define FSR_LOAD_LONG_US    1000
// Cycles per microsecond first, so the product stays inside 32 bits
`define FSR_US_TO_CYC(us)   ((us) * (`FSR_CLK_HZ / 1000000))
`define FSR_CNT_W           14

`endif

// file: verilog/fsr_pkg.sv
// Types for the status register bank.
// Shared by the bank and its supply test sequencer.
package fsr_pkg;
   // Lock key recogniser states
   typedef enum logic [1:0] {FSR_LK_IDLE, FSR_LK_CMD, FSR_LK_KEY1, FSR_LK_SKIP} fsr_lock_st_t;
   // Supply test sequencer states
   typedef enum logic [1:0] {FSR_ST_IDLE, FSR_ST_LOAD, FSR_ST_CMP} fsr_test_st_t;
endpackage : fsr_pkg

// file: verilog/fsr_dummy_map.sv
// Maps the dummy-count code to a clock count.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "fsr_consts.svh"
module fsr_dummy_map
   import fsr_pkg::*;
(
   input  wire logic [2:0] code,
   output logic      [3:0] clocks,
   output logic            reserved
);
   // Code to count, mode-bit clocks already inside
   always_comb begin
      reserved = 1'b0;
      unique case (code)
         `FSR_DCODE_2:  clocks = `FSR_DCLK_2;
         `FSR_DCODE_4:  clocks = `FSR_DCLK_4;
         `FSR_DCODE_6:  clocks = `FSR_DCLK_6;
         `FSR_DCODE_8:  clocks = `FSR_DCLK_8;
         `FSR_DCODE_10: clocks = `FSR_DCLK_10;
         default: begin
            clocks   = `FSR_DCLK_2;
            reserved = 1'b1;
         end
      endcase
   end
endmodule : fsr_dummy_map

// file: verilog/fsr_supply_test.sv
// Supply test sequencer: load, wait, compare, report.
// Comparator level is sampled only in the compare state.
`timescale 1ns/10ps
`include "fsr_consts.svh"
module fsr_supply_test
   import fsr_pkg::*;
#(
   parameter int LONG_CYC = `FSR_US_TO_CYC(`FSR_LOAD_LONG_US)
)(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic       long_sel,
   input  wire logic       below,
   output logic            load_on_r,
   output logic      [1:0] result_r
);
   localparam logic [`FSR_CNT_W-1:0] SHORT_N =
      `FSR_CNT_W'(`FSR_US_TO_CYC(`FSR_LOAD_SHORT_US));
   localparam logic [`FSR_CNT_W-1:0] LONG_N = `FSR_CNT_W'(LONG_CYC);

   fsr_test_st_t            st_r;
   logic [`FSR_CNT_W-1:0]   cnt_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= FSR_ST_IDLE;
      end else if (abort) begin
         st_r <= FSR_ST_IDLE;
      end else begin
         unique case (st_r)
            FSR_ST_IDLE: if (start) st_r <= FSR_ST_LOAD;
            FSR_ST_LOAD: if (cnt_r == `FSR_CNT_W'(1)) st_r <= FSR_ST_CMP;
            FSR_ST_CMP:  st_r <= FSR_ST_IDLE;
            // Unused code falls back to idle
            default:     st_r <= FSR_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= '0;
      end else if (st_r == FSR_ST_IDLE && start) begin
         cnt_r <= long_sel ? LONG_N : SHORT_N;
      end else if (st_r == FSR_ST_LOAD) begin
         cnt_r <= cnt_r - `FSR_CNT_W'(1);
      end
   end

   // Load drive
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_on_r <= 1'b0;
      end else begin
         load_on_r <= !abort && ((st_r == FSR_ST_IDLE && start) ||
                      (st_r == FSR_ST_LOAD && cnt_r != `FSR_CNT_W'(1)));
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_r <= `FSR_RES_IDLE;
      end else if (abort) begin
         result_r <= `FSR_RES_IDLE;
      end else if (st_r == FSR_ST_IDLE && start) begin
         result_r <= `FSR_RES_BUSY;
      end else if (st_r == FSR_ST_CMP) begin
         result_r <= below ? `FSR_RES_BELOW : `FSR_RES_ABOVE;
      end
   end

   sequence s_cmp_below;
      st_r == FSR_ST_CMP && below && !abort;
   endsequence
   property p_result_below;
      @(posedge clk) disable iff (sys_rst) s_cmp_below |=> result_r == `FSR_RES_BELOW;
   endproperty
   a_result_below: assert property (p_result_below) else $error("below not reported");
   property p_busy;
      @(posedge clk) disable iff (sys_rst)
         st_r == FSR_ST_IDLE && start && !abort |=> result_r == `FSR_RES_BUSY && load_on_r;
   endproperty
   a_busy: assert property (p_busy) else $error("test start not shown");
   sequence s_load_short;
      $rose(load_on_r) && cnt_r == SHORT_N;
   endsequence
   property p_load_hold;
      @(posedge clk) disable iff (sys_rst || abort)
         s_load_short |-> load_on_r [*8] ##0 result_r == `FSR_RES_BUSY;
   endproperty
   a_load_hold: assert property (p_load_hold) else $error("load dropped early");
   property p_order;
      @(posedge clk) disable iff (sys_rst)
         $fell(load_on_r) && !$past(abort) |-> st_r == FSR_ST_CMP;
   endproperty
   a_order: assert property (p_order) else $error("compare not after load");
endmodule : fsr_supply_test

// file: verilog/fsr_status_regs.sv
// Fifth and sixth status registers of the serial flash.
// Assumes the command decoder hands in bytes and decoded strobes.
//
// Contract
// - lock sets after 6F, 4D, 67 only
// - lock is sticky, blocks writes, resets zero
// - dummy codes give 2, 4, 6, 8, 10 clocks
// - dummy count includes two mode-bit clocks
// - erase suspend sets read-only flag
// - program suspend sets read-only flag
// - abort commands ignored unless enabled
// - abort enable changes by write or power
// - aligned read forces low address bits zero
// - alignment bit affects only aligned read
// - battery status command reports test state
// - result codes idle, busy, above, below
// - threshold 1.8 V to 3.2 V, 0.2 V steps
// - below threshold loads result 11
// - load select 10 uA to 10 mA
// - load, wait, compare, then report
// - load held 100 us or 1 ms
`timescale 1ns/10ps
`include "fsr_consts.svh"
module fsr_status_regs
   import fsr_pkg::*;
#(
   parameter int LONG_CYC = `FSR_US_TO_CYC(`FSR_LOAD_LONG_US)
)(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        byte_valid,
   input  wire logic        byte_first,
   input  wire logic [7:0]  byte_data,
   input  wire logic        frame_end,
   input  wire logic        wr5_stb,
   input  wire logic        wr6_stb,
   input  wire logic [7:0]  wr_data,
   input  wire logic        erase_susp_set,
   input  wire logic        erase_susp_clr,
   input  wire logic        prog_susp_set,
   input  wire logic        prog_susp_clr,
   input  wire logic        abort_req,
   input  wire logic        xip_start,
   input  wire logic        xip_aligned_cmd,
   input  wire logic [23:0] xip_addr_in,
   input  wire logic        supply_test_cmd,
   input  wire logic        supply_below,
   output logic      [7:0]  rd5_data_r,
   output logic      [7:0]  rd6_data_r,
   output logic             status_lock_flag_r,
   output logic             abort_go_r,
   output logic      [23:0] xip_addr_r,
   output logic      [3:0]  xip_dummy_clks_r,
   output logic      [3:0]  xip_pad_clks_r,
   output logic      [2:0]  supply_load_sel_r,
   output logic             supply_load_on_r,
   output logic      [11:0] supply_thresh_mv_r
);
   fsr_lock_st_t lk_st_r;
   logic [2:0]   xip_dummy_count_r;
   logic         erase_paused_flag_r;
   logic         program_paused_flag_r;
   logic         abort_cmd_enable_r;
   logic         word_aligned_addr_r;
   logic [2:0]   thresh_sel_r;
   logic [1:0]   load_sel_r;
   logic         supply_load_time_r;
   logic [1:0]   supply_test_result;
   logic         load_on;
   logic [3:0]   dmy_clocks;
   logic         dmy_reserved;
   logic [3:0]   dmy_clocks_new;
   logic         dmy_reserved_new;
   logic         wr5_ok;
   logic         wr6_ok;
   logic         abort_take;

   assign wr5_ok     = wr5_stb && !status_lock_flag_r;
   assign wr6_ok     = wr6_stb && !status_lock_flag_r;
   assign abort_take = abort_req && abort_cmd_enable_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lk_st_r <= FSR_LK_IDLE;
      end else if (frame_end) begin
         lk_st_r <= FSR_LK_IDLE;
      end else if (byte_valid) begin
         if (byte_first) begin
            lk_st_r <= (byte_data == `FSR_OP_LOCK) ? FSR_LK_CMD : FSR_LK_SKIP;
         end else begin
            unique case (lk_st_r)
               FSR_LK_CMD:  lk_st_r <= (byte_data == `FSR_LOCK_KEY1) ? FSR_LK_KEY1 : FSR_LK_SKIP;
               FSR_LK_KEY1: lk_st_r <= FSR_LK_SKIP;
               FSR_LK_IDLE: lk_st_r <= FSR_LK_IDLE;
               FSR_LK_SKIP: lk_st_r <= FSR_LK_SKIP;
            endcase
         end
      end
   end

   // lock flag set on second key
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_lock_flag_r <= 1'b0;
      end else if (byte_valid && !byte_first && !frame_end && lk_st_r == FSR_LK_KEY1 &&
                   byte_data == `FSR_LOCK_KEY2) begin
         status_lock_flag_r <= 1'b1;
      end
   end

   fsr_dummy_map u_dmy_now (
      .code     (xip_dummy_count_r),
      .clocks   (dmy_clocks),
      .reserved (dmy_reserved)
   );
   fsr_dummy_map u_dmy_new (
      .code     (wr_data[`FSR_R5_DUMMY_HI:`FSR_R5_DUMMY_LO]),
      .clocks   (dmy_clocks_new),
      .reserved (dmy_reserved_new)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         xip_dummy_count_r <= `FSR_DUMMY_RST;
      end else if (wr5_ok && !dmy_reserved_new) begin
         xip_dummy_count_r <= wr_data[`FSR_R5_DUMMY_HI:`FSR_R5_DUMMY_LO];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         abort_cmd_enable_r  <= 1'b0;
         word_aligned_addr_r <= 1'b0;
      end else if (wr5_ok) begin
         abort_cmd_enable_r  <= wr_data[`FSR_R5_ABORT_EN];
         word_aligned_addr_r <= wr_data[`FSR_R5_ALIGN];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         erase_paused_flag_r <= 1'b0;
      end else if (erase_susp_set) begin
         erase_paused_flag_r <= 1'b1;
      end else if (erase_susp_clr) begin
         erase_paused_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         program_paused_flag_r <= 1'b0;
      end else if (prog_susp_set) begin
         program_paused_flag_r <= 1'b1;
      end else if (prog_susp_clr) begin
         program_paused_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         abort_go_r <= 1'b0;
      end else begin
         abort_go_r <= abort_take;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         thresh_sel_r       <= `FSR_THR_RST;
         load_sel_r         <= `FSR_LOAD_RST;
         supply_load_time_r <= 1'b0;
      end else if (wr6_ok) begin
         thresh_sel_r       <= wr_data[`FSR_R6_THR_HI:`FSR_R6_THR_LO];
         load_sel_r         <= wr_data[`FSR_R6_LOAD_HI:`FSR_R6_LOAD_LO];
         supply_load_time_r <= wr_data[`FSR_R6_TIME];
      end
   end

   // command starts and reports the test
   fsr_supply_test #(
      .LONG_CYC (LONG_CYC)
   ) u_test (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .start     (supply_test_cmd),
      .abort     (abort_take),
      .long_sel  (supply_load_time_r),
      .below     (supply_below),
      .load_on_r (load_on),
      .result_r  (supply_test_result)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         supply_load_on_r   <= 1'b0;
         supply_load_sel_r  <= 3'h0;
         supply_thresh_mv_r <= `FSR_THR_BASE_MV;
      end else begin
         supply_load_on_r   <= load_on;
         supply_load_sel_r  <= {1'b0, load_sel_r};
         supply_thresh_mv_r <= `FSR_THR_BASE_MV + 12'(thresh_sel_r * `FSR_THR_STEP_MV);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         xip_addr_r <= 24'h0;
      end else if (xip_start) begin
         xip_addr_r <= (xip_aligned_cmd && word_aligned_addr_r) ?
                       {xip_addr_in[23:2], 2'h0} : xip_addr_in;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         xip_dummy_clks_r <= `FSR_DCLK_2;
         xip_pad_clks_r   <= 4'h0;
      end else if (xip_start) begin
         xip_dummy_clks_r <= dmy_clocks;
         xip_pad_clks_r   <= dmy_clocks - `FSR_MODE_CLKS;
      end
   end

   // Read-back images
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd5_data_r <= 8'h0;
         rd6_data_r <= 8'h0;
      end else begin
         rd5_data_r <= {status_lock_flag_r, xip_dummy_count_r, erase_paused_flag_r,
                        program_paused_flag_r, abort_cmd_enable_r, word_aligned_addr_r};
         rd6_data_r <= {supply_test_result, thresh_sel_r, load_sel_r, supply_load_time_r};
      end
   end

   sequence s_key_done;
      byte_valid && !byte_first && !frame_end && lk_st_r == FSR_LK_KEY1 &&
      byte_data == `FSR_LOCK_KEY2;
   endsequence
   property p_lock_cause;
      @(posedge clk) disable iff (sys_rst)
         $rose(status_lock_flag_r) |-> $past(lk_st_r == FSR_LK_KEY1);
   endproperty
   a_lock_cause: assert property (p_lock_cause) else $error("lock without keys");
   property p_lock_set;
      @(posedge clk) disable iff (sys_rst) s_key_done |=> status_lock_flag_r ##1 status_lock_flag_r;
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock not set or lost");
   property p_locked_frozen;
      @(posedge clk) disable iff (sys_rst)
         status_lock_flag_r |=> $stable(xip_dummy_count_r) && $stable(abort_cmd_enable_r);
   endproperty
   a_locked_frozen: assert property (p_locked_frozen) else $error("write while locked");
   property p_dmy10;
      @(posedge clk) disable iff (sys_rst)
         xip_start && xip_dummy_count_r == `FSR_DCODE_10 |=> xip_dummy_clks_r == `FSR_DCLK_10;
   endproperty
   a_dmy10: assert property (p_dmy10) else $error("dummy count wrong");
   property p_dmy8;
      @(posedge clk) disable iff (sys_rst)
         xip_start && xip_dummy_count_r == `FSR_DCODE_8 |=> xip_dummy_clks_r == `FSR_DCLK_8;
   endproperty
   a_dmy8: assert property (p_dmy8) else $error("code 011 not 8");
   property p_dmy_legal;
      @(posedge clk) disable iff (sys_rst)
         wr5_ok && dmy_reserved_new |=> $stable(xip_dummy_count_r) && !dmy_reserved;
   endproperty
   a_dmy_legal: assert property (p_dmy_legal) else $error("reserved code stored");
   property p_pad;
      @(posedge clk) disable iff (sys_rst)
         xip_start |=> xip_pad_clks_r + `FSR_MODE_CLKS == xip_dummy_clks_r &&
                       xip_pad_clks_r == {$past(xip_dummy_count_r), 1'b0};
   endproperty
   a_pad: assert property (p_pad) else $error("mode clocks added twice");
   property p_erase;
      @(posedge clk) disable iff (sys_rst)
         erase_susp_set |=> erase_paused_flag_r ##1 rd5_data_r[`FSR_R5_ERASE_SUSP];
   endproperty
   a_erase: assert property (p_erase) else $error("erase flag missed");
   property p_prog;
      @(posedge clk) disable iff (sys_rst) prog_susp_set |=> program_paused_flag_r;
   endproperty
   a_prog: assert property (p_prog) else $error("program flag missed");
   property p_abort;
      @(posedge clk) disable iff (sys_rst) abort_req |=> abort_go_r == $past(abort_cmd_enable_r);
   endproperty
   a_abort: assert property (p_abort) else $error("abort gating wrong");
   property p_align;
      @(posedge clk) disable iff (sys_rst)
         xip_start && xip_aligned_cmd && word_aligned_addr_r |=> xip_addr_r[1:0] == 2'h0;
   endproperty
   a_align: assert property (p_align) else $error("low address bits kept");
   property p_plain;
      @(posedge clk) disable iff (sys_rst)
         xip_start && !xip_aligned_cmd |=> xip_addr_r == $past(xip_addr_in);
   endproperty
   a_plain: assert property (p_plain) else $error("plain read altered");
endmodule : fsr_status_regs

// file: sim/fsr_host_model.sv
// Host controller model: hands command bytes and register writes to the bank.
// Assumes one clock; every change lands 1 ns after a rising edge.
`timescale 1ns/10ps
module fsr_host_model
   import fsr_pkg::*;
(
   input  wire logic       clk,
   output logic            byte_valid,
   output logic            byte_first,
   output logic      [7:0] byte_data,
   output logic            frame_end,
   output logic            wr5_stb,
   output logic            wr6_stb,
   output logic      [7:0] wr_data
);
   // Quiet lines at start; data carries junk while unqualified
   initial begin
      byte_valid = 1'b0;
      byte_first = 1'b0;
      byte_data  = 8'h5a;
      frame_end  = 1'b0;
      wr5_stb    = 1'b0;
      wr6_stb    = 1'b0;
      wr_data    = 8'ha5;
   end

   // Wait for the next edge, then settle
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   // One frame byte; valid stays up for a following byte
   task automatic send(input logic [7:0] b, input logic f);
      byte_valid = 1'b1;
      byte_first = f;
      byte_data  = b;
      step();
   endtask : send

   // Release byte lines; data turns to the inverse of its last value
   task automatic idle();
      byte_valid = 1'b0;
      byte_first = 1'b0;
      byte_data  = ~byte_data;
      step();
   endtask : idle

   // Chip select released
   task automatic fend();
      frame_end = 1'b1;
      step();
      frame_end = 1'b0;
      step();
   endtask : fend

   task automatic lock_seq();
      send(8'h6f, 1'b1);
      send(8'h4d, 1'b0);
      send(8'h67, 1'b0);
      idle();
   endtask : lock_seq

   // One register write strobe, data scrambled afterwards
   task automatic wr(input logic r6, input logic [7:0] d);
      wr5_stb = ~r6;
      wr6_stb = r6;
      wr_data = d;
      step();
      wr5_stb = 1'b0;
      wr6_stb = 1'b0;
      wr_data = ~d;
      step();
   endtask : wr
endmodule : fsr_host_model

// file: sim/fsr_status_regs_tb.sv
// Self-checking bench for the fifth and sixth status registers.
// Assumes the host model drives command bytes and register writes.
`timescale 1ns/10ps
module fsr_status_regs_tb
   import fsr_pkg::*;
   ;
   localparam int LONG = 20;
   typedef struct {logic r6; logic [7:0] wd; logic [7:0] ex;} fsr_row_t;
   logic        clk, sys_rst, xip_al, below, byte_valid, byte_first, frame_end;
   logic        wr5_stb, wr6_stb, lock, go, lon;
   logic [7:0]  pls, byte_data, wr_data, rd5, rd6;
   logic [23:0] xip_addr, xaddr;
   logic [3:0]  dclk, pad;
   logic [2:0]  lsel;
   logic [11:0] thr;
   int          errors, n_tests, n;
   fsr_row_t    rows [14];

   fsr_host_model host (.clk(clk), .byte_valid(byte_valid), .byte_first(byte_first),
      .byte_data(byte_data), .frame_end(frame_end), .wr5_stb(wr5_stb),
      .wr6_stb(wr6_stb), .wr_data(wr_data));

   fsr_status_regs #(.LONG_CYC(LONG)) fsr_status_regs_inst (.clk(clk), .sys_rst(sys_rst),
      .byte_valid(byte_valid), .byte_first(byte_first), .byte_data(byte_data),
      .frame_end(frame_end), .wr5_stb(wr5_stb), .wr6_stb(wr6_stb), .wr_data(wr_data),
      .erase_susp_set(pls[0]), .erase_susp_clr(pls[1]), .prog_susp_set(pls[2]),
      .prog_susp_clr(pls[3]), .abort_req(pls[4]), .xip_start(pls[5]),
      .xip_aligned_cmd(xip_al), .xip_addr_in(xip_addr), .supply_test_cmd(pls[6]),
      .supply_below(below), .rd5_data_r(rd5), .rd6_data_r(rd6),
      .status_lock_flag_r(lock), .abort_go_r(go), .xip_addr_r(xaddr),
      .xip_dummy_clks_r(dclk), .xip_pad_clks_r(pad), .supply_load_sel_r(lsel),
      .supply_load_on_r(lon), .supply_thresh_mv_r(thr));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk_v

   // Pulse strobes for one cycle, then drop them
   task automatic pulse(input logic [7:0] m);
      pls = m;
      tick(1);
      pls = 8'h00;
      tick(1);
   endtask : pulse

   // Terminate request; count cycles of the go pulse
   task automatic try_abort(input logic [23:0] exp);
      n = 0;
      pls = 8'h10;
      tick(1);
      pls = 8'h00;
      repeat (3) begin
         if (go === 1'b1) n++;
         tick(1);
      end
      chk_v(24'(n), exp);
   endtask : try_abort

   // Wait while the supply test reports busy
   task automatic wait_done();
      n = 0;
      while (rd6[7:6] === 2'b01 && n < 300) begin
         tick(1);
         n++;
      end
   endtask : wait_done

   function automatic logic [3:0] dclk_of(input logic [2:0] c);
      return 4'h2 + {c, 1'b0};
   endfunction : dclk_of

   task automatic print_verdict();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   // Hang guard: the run needs about 1200 cycles
   initial begin
      #600000;
      errors++;
      print_verdict();
   end

   // Main sequence
   initial begin
      errors = 0;
      n_tests = 0;
      sys_rst = 1'b1;
      pls = 8'h00;
      xip_al = 1'b1;
      xip_addr = 24'h123457;
      below = 1'b1;
      rows[0] = '{1'b0, 8'h01, 8'h01};
      rows[1] = '{1'b0, 8'h12, 8'h12};
      rows[2] = '{1'b0, 8'h2c, 8'h20};
      rows[3] = '{1'b0, 8'hb0, 8'h30};
      rows[4] = '{1'b0, 8'h43, 8'h43};
      rows[5] = '{1'b0, 8'h5e, 8'h42};
      for (int i = 0; i < 8; i++) begin
         rows[6 + i] = '{1'b1, {2'b11, 3'(i), 2'(i % 4), 1'(i % 2)},
                         {2'b00, 3'(i), 2'(i % 4), 1'(i % 2)}};
      end
      tick(20);
      sys_rst = 1'b0;
      tick(1);
      chk_v(24'(rd5), 24'h0);
      chk_v(24'(rd6), 24'h0);
      chk_v(24'(dclk), 24'h2);
      chk_v(24'(thr), 24'h708);
      // Table of register writes
      for (int i = 0; i < 14; i++) begin
         host.wr(rows[i].r6, rows[i].wd);
         tick(1);
         if (rows[i].r6) begin
            chk_v(24'(rd6), 24'(rows[i].ex));
            chk_v(24'(thr), 24'(12'd1800 + 12'd200 * rows[i].ex[5:3]));
            chk_v(24'(lsel), 24'(rows[i].ex[2:1]));
         end else begin
            pulse(8'h20);
            chk_v(24'(rd5), 24'(rows[i].ex));
            chk_v(24'(dclk), 24'(dclk_of(rows[i].ex[6:4])));
            chk_v(24'(pad), 24'(dclk_of(rows[i].ex[6:4]) - 4'h2));
            chk_v(xaddr, rows[i].ex[0] ? 24'h123454 : 24'h123457);
         end
      end
      // Alignment ignored for the plain read; terminate gating
      host.wr(1'b0, 8'h03);
      xip_al = 1'b0;
      pulse(8'h20);
      chk_v(xaddr, 24'h123457);
      try_abort(24'h1);
      chk_v(24'(rd5), 24'h03);
      host.wr(1'b0, 8'h01);
      try_abort(24'h0);
      // Suspend flags: set, survive a write, clear
      pulse(8'h05);
      tick(1);
      chk_v(24'(rd5), 24'h0d);
      host.wr(1'b0, 8'h01);
      tick(1);
      chk_v(24'(rd5), 24'h0d);
      pulse(8'h0b);
      tick(1);
      chk_v(24'(rd5), 24'h09);
      pulse(8'h02);
      tick(1);
      chk_v(24'(rd5), 24'h01);
      // Long test, supply below threshold
      pulse(8'h40);
      chk_v(24'(rd6), 24'h7f);
      chk_v(24'(lon), 24'h1);
      tick(12);
      chk_v(24'(rd6[7:6]), 24'h1);
      wait_done();
      chk_v(24'(rd6), 24'hff);
      chk_v(24'(lon), 24'h0);
      // Short test, supply above threshold
      host.wr(1'b1, 8'h12);
      below = 1'b0;
      pulse(8'h40);
      tick(900);
      chk_v(24'(rd6[7:6]), 24'h1);
      wait_done();
      chk_v(24'(rd6), 24'h92);
      // Enabled terminate drops a running test
      host.wr(1'b0, 8'h02);
      host.wr(1'b1, 8'h13);
      pulse(8'h40);
      tick(3);
      pulse(8'h10);
      tick(2);
      chk_v(24'(rd6), 24'h13);
      // Broken key orders, then the real one
      host.fend();
      host.send(8'h6f, 1'b1);
      host.send(8'h67, 1'b0);
      host.send(8'h4d, 1'b0);
      host.idle();
      host.fend();
      host.send(8'h6f, 1'b1);
      host.send(8'h4d, 1'b0);
      host.idle();
      host.fend();
      host.send(8'h67, 1'b0);
      host.idle();
      chk_v(24'(lock), 24'h0);
      host.fend();
      host.lock_seq();
      chk_v(24'(lock), 24'h1);
      host.wr(1'b0, 8'h00);
      host.wr(1'b1, 8'h00);
      host.fend();
      chk_v(24'(rd5), 24'h82);
      chk_v(24'(rd6), 24'h13);
      // Power cycle clears lock and terminate enable
      sys_rst = 1'b1;
      tick(2);
      sys_rst = 1'b0;
      tick(2);
      chk_v(24'(rd5), 24'h0);
      print_verdict();
   end
endmodule : fsr_status_regs_tb
